// File: hw/rsc_pkg.sv
// shared constants and types of the reset source controller
package rsc_pkg;
	localparam logic [7:0] SFR_SUPPLY_CTRL = 8'hff;
	localparam logic [7:0] SFR_RESET_CAUSE = 8'hef;

	// supply_monitor_control fields
	localparam int MON_ON_BIT = 7;
	localparam int MON_ABOVE_RST_BIT = 6;
	localparam int MON_ABOVE_WARN_BIT = 5;
	localparam logic [4:0] MON_LOW_READ = 5'h00;

	// reset_cause_register fields
	localparam int RTC_BIT = 7;
	localparam int COMP_BIT = 5;
	localparam int SW_BIT = 4;
	localparam int MCD_BIT = 2;
	localparam int POR_BIT = 1;

	localparam int CLK_MHZ = 250;
	localparam int MCD_TIME_US = 100;
	localparam int MCD_CYCLES = MCD_TIME_US * CLK_MHZ;
	localparam int POR_DELAY_US = 7000;
	localparam int POR_DELAY_CYCLES = POR_DELAY_US * CLK_MHZ;
	localparam int WDT_DIV = 12;
	localparam int HOLD_MIN = 4;

	localparam int SYNC_W = 7;
	// idle levels: above reset, above warning, pin high, rest low
	localparam logic [SYNC_W-1:0] SYNC_INIT = 7'h62;

	typedef struct packed {
		logic rtc;
		logic flash;
		logic comp;
		logic sw;
		logic wdt;
		logic clock_loss_detector;
		logic por;
		logic pin;
	} rsc_cause_t;

	typedef struct packed {
		logic wrAboveLock;
		logic readAboveLock;
		logic branchAboveLock;
		logic securityBlock;
		logic wrAttempt;
	} rsc_flash_t;

	typedef struct packed {
		logic aboveReset;
		logic aboveWarn;
		logic compLow;
		logic rtcAlarm;
		logic rtcOscFail;
		logic pinLevel;
		logic monClk;
	} rsc_async_t;

	localparam rsc_cause_t CAUSE_NONE = 8'h00;
endpackage

// File: hw/rsc_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module rsc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic sys_clk,
	input wire logic ce,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= INIT;
			q <= INIT;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// File: hw/rsc_clock_loss.sv
// missing clock one-shot: times out when the watched clock stops toggling
`timescale 1ns/1ps
module rsc_clock_loss #(
	parameter int LIMIT = rsc_pkg::MCD_CYCLES
) (
	input wire logic sys_clk,
	input wire logic ce,
	input wire logic rst,
	input wire logic enable,
	input wire logic watched,
	output logic timeout
);
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIM = CW'(LIMIT);
	logic [CW-1:0] count_q;
	logic last_q;

	// any edge rearms; disabled detector never times out
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_q <= '0;
			last_q <= 1'h0;
			timeout <= 1'h0;
		end else if (ce) begin
			last_q <= watched;
			if (!enable || watched != last_q) begin
				count_q <= '0;
				timeout <= 1'h0;
			end else if (count_q == LIM) begin
				timeout <= 1'h1;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end
endmodule

// File: hw/rsc_reset_ctrl.sv
// reset source controller: request gathering, cause flags, registers
//
// What this block does
// - supply monitor reset releases without the power-on delay.
// - monitor on bit resets to one; resets only when also selected.
// - read-only bits show supply above reset and above warning levels.
// - control bits 4:2 read zero, written zero; bits 1:0 read zero.
// - low reset pin resets the device, also in suspend and sleep.
// - pin reset sets the pin flag at bit 0.
// - enabled detector resets after clock stuck over 100 us.
// - bit 2 reads clock-loss cause; writing sets detector enable.
// - clock-loss reset masked in low power, enable kept for exit.
// - bit 5 write enables comparator reset; low comparator starts a reset.
// - bit 5 reads comparator cause; low power needs wake enable.
// - watchdog runs from clock over 12 after reset; expiry resets.
// - watchdog reset masked in low power, enable kept for exit.
// - illegal flash accesses or writes with monitor off reset.
// - flash fault reset sets read-only flag at bit 6.
// - bit 7 enables clock alarm or oscillator failure reset, always.
// - writing one to bit 4 forces reset; bit 4 then reads one.
// - internal resets except supply resets leave the reset pin undriven.
// - power-on flag set by power and supply resets, clears others.
`timescale 1ns/1ps
module rsc_reset_ctrl #(
	parameter int MCD_LIMIT = rsc_pkg::MCD_CYCLES,
	parameter int POR_DELAY = rsc_pkg::POR_DELAY_CYCLES
) (
	input wire logic sys_clk,
	input wire logic ce,
	input wire logic rst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrWrData,
	output logic [7:0] sfrRdData,
	input wire logic rstPinIn,
	output logic rstPinOut,
	output logic rstPinOe,
	input wire logic supplyAboveReset,
	input wire logic supplyAboveWarn,
	output logic supplyMonitorOn,
	input wire logic compOutLow,
	input wire logic compWakeEn,
	input wire logic monClk,
	input wire logic wdtExpire,
	input wire logic wdtStop,
	output logic wdtRun,
	output logic wdtTick,
	input wire rsc_pkg::rsc_flash_t flashAcc,
	input wire logic rtcAlarm,
	input wire logic rtcOscFail,
	input wire logic lowPower,
	output logic sysRst,
	output logic porDelayActive
);
	typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY} rsc_state_t;

	localparam int PW = $clog2(POR_DELAY + 1);
	localparam logic [PW-1:0] POR_LIM = PW'(POR_DELAY);
	localparam logic [2:0] HOLD_LIM = 3'(rsc_pkg::HOLD_MIN);
	localparam logic [3:0] WDT_LIM = 4'(rsc_pkg::WDT_DIV - 1);

	rsc_state_t state_q;
	rsc_pkg::rsc_async_t async_s;
	rsc_pkg::rsc_cause_t req;
	rsc_pkg::rsc_cause_t cause_q;
	rsc_pkg::rsc_cause_t flags_q;
	logic monOn_q;
	logic monSel_q;
	logic mcdEn_q;
	logic compEn_q;
	logic rtcEn_q;
	logic swReq_q;
	logic [2:0] quiet_q;
	logic [PW-1:0] delay_q;
	logic [3:0] wdtDiv_q;
	logic [1:0] oeTail_q;
	logic mcdTimeout;
	logic flashFault;
	logic wrCause;
	logic wrMon;

	rsc_sync #(
		.W(rsc_pkg::SYNC_W),
		.INIT(rsc_pkg::SYNC_INIT)
	) u_sync (
		.sys_clk(sys_clk),
		.ce(ce),
		.rst(rst),
		.d({supplyAboveReset, supplyAboveWarn, compOutLow, rtcAlarm,
			rtcOscFail, rstPinIn, monClk}),
		.q(async_s)
	);

	rsc_clock_loss #(
		.LIMIT(MCD_LIMIT)
	) u_clock_loss (
		.sys_clk(sys_clk),
		.ce(ce),
		.rst(rst),
		.enable(mcdEn_q && !lowPower),
		.watched(async_s.monClk),
		.timeout(mcdTimeout)
	);

	// writes are only accepted while the core runs
	assign wrCause = sfrWrEn && state_q == ST_RUN &&
		sfrAddr == rsc_pkg::SFR_RESET_CAUSE;
	assign wrMon = sfrWrEn && state_q == ST_RUN &&
		sfrAddr == rsc_pkg::SFR_SUPPLY_CTRL;

	assign flashFault = flashAcc.wrAboveLock || flashAcc.readAboveLock ||
		flashAcc.branchAboveLock || flashAcc.securityBlock ||
		(flashAcc.wrAttempt && !monOn_q);

	always_comb begin
		req = rsc_pkg::CAUSE_NONE;
		// pin still reads low for two synchroniser cycles after drive ends
		req.pin = !async_s.pinLevel && !rstPinOe &&
			oeTail_q == '0;
		// supply monitor is off in sleep, so no power-fail reset then
		req.por = monOn_q && monSel_q && !async_s.aboveReset &&
			!lowPower;
		req.clock_loss_detector = mcdTimeout;
		req.comp = compEn_q && async_s.compLow &&
			(!lowPower || compWakeEn);
		req.wdt = wdtRun && wdtExpire && !lowPower;
		req.flash = flashFault;
		req.rtc = rtcEn_q && (async_s.rtcAlarm || async_s.rtcOscFail);
		req.sw = swReq_q;
	end

	// history of own pin drive, masks the synchroniser lag on release
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			oeTail_q <= '1;
		end else if (ce) begin
			oeTail_q <= {oeTail_q[0], rstPinOe};
		end
	end

	// state sequencing
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ST_HOLD;
			quiet_q <= '0;
			delay_q <= '0;
		end else if (ce) begin
			unique case (state_q)
				ST_RUN: begin
					quiet_q <= '0;
					if (req != rsc_pkg::CAUSE_NONE) begin
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					// quiet window outlasts the pin synchroniser
					if (req != rsc_pkg::CAUSE_NONE) begin
						quiet_q <= '0;
					end else if (quiet_q != HOLD_LIM) begin
						quiet_q <= quiet_q + 1'b1;
					end else if (cause_q == rsc_pkg::CAUSE_NONE) begin
						delay_q <= '0;
						state_q <= ST_DELAY;
					end else begin
						state_q <= ST_RUN;
					end
				end
				ST_DELAY: begin
					if (req != rsc_pkg::CAUSE_NONE) begin
						quiet_q <= '0;
						state_q <= ST_HOLD;
					end else if (delay_q == POR_LIM) begin
						state_q <= ST_RUN;
					end else begin
						delay_q <= delay_q + 1'b1;
					end
				end
			endcase
		end
	end

	// first cause wins; none latched means power-on
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cause_q <= rsc_pkg::CAUSE_NONE;
		end else if (ce) begin
			if (state_q == ST_RUN) begin
				cause_q <= req;
			end else if (state_q == ST_HOLD && cause_q == rsc_pkg::CAUSE_NONE) begin
				cause_q <= req;
			end
		end
	end

	// flags captured on release into run
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flags_q <= rsc_pkg::CAUSE_NONE;
		end else if (ce && state_q != ST_RUN && sysRstNext() == 1'h0) begin
			flags_q <= cause_q;
			if (cause_q == rsc_pkg::CAUSE_NONE || cause_q.por) begin
				flags_q <= rsc_pkg::CAUSE_NONE;
				flags_q.por <= 1'h1;
			end
		end
	end

	function automatic logic sysRstNext();
		sysRstNext = !((state_q == ST_HOLD && req == rsc_pkg::CAUSE_NONE &&
			quiet_q == HOLD_LIM && cause_q != rsc_pkg::CAUSE_NONE) ||
			(state_q == ST_DELAY && req == rsc_pkg::CAUSE_NONE &&
			delay_q == POR_LIM));
	endfunction

	// monitor enable and selection return to on only on power-on and supply resets
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			monOn_q <= 1'h1;
			monSel_q <= 1'h1;
		end else if (ce) begin
			if (state_q != ST_RUN && (cause_q.por ||
				cause_q == rsc_pkg::CAUSE_NONE)) begin
				monOn_q <= 1'h1;
				monSel_q <= 1'h1;
			end else begin
				if (wrMon) begin
					monOn_q <= sfrWrData[rsc_pkg::MON_ON_BIT];
				end
				if (wrCause) begin
					monSel_q <= sfrWrData[rsc_pkg::POR_BIT];
				end
			end
		end
	end

	// other source enables return to off on any reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mcdEn_q <= 1'h0;
			compEn_q <= 1'h0;
			rtcEn_q <= 1'h0;
			swReq_q <= 1'h0;
		end else if (ce) begin
			swReq_q <= wrCause && sfrWrData[rsc_pkg::SW_BIT];
			if (state_q != ST_RUN) begin
				mcdEn_q <= 1'h0;
				compEn_q <= 1'h0;
				rtcEn_q <= 1'h0;
			end else if (wrCause) begin
				mcdEn_q <= sfrWrData[rsc_pkg::MCD_BIT];
				compEn_q <= sfrWrData[rsc_pkg::COMP_BIT];
				rtcEn_q <= sfrWrData[rsc_pkg::RTC_BIT];
			end
		end
	end

	// watchdog restarts enabled with a divide-by-12 tick
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wdtRun <= 1'h1;
			wdtDiv_q <= '0;
			wdtTick <= 1'h0;
		end else if (ce) begin
			if (state_q != ST_RUN) begin
				wdtRun <= 1'h1;
				wdtDiv_q <= '0;
				wdtTick <= 1'h0;
			end else begin
				if (wdtStop) begin
					wdtRun <= 1'h0;
				end
				wdtTick <= wdtDiv_q == WDT_LIM;
				wdtDiv_q <= (wdtDiv_q == WDT_LIM) ? '0 : wdtDiv_q + 1'b1;
			end
		end
	end

	// read data registered
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sfrRdData <= '0;
		end else if (ce && sfrRdEn) begin
			if (sfrAddr == rsc_pkg::SFR_SUPPLY_CTRL) begin
				sfrRdData <= {monOn_q, async_s.aboveReset,
					async_s.aboveWarn, rsc_pkg::MON_LOW_READ};
			end else if (sfrAddr == rsc_pkg::SFR_RESET_CAUSE) begin
				sfrRdData <= flags_q;
			end else begin
				sfrRdData <= '0;
			end
		end
	end

	assign sysRst = state_q != ST_RUN;
	assign supplyMonitorOn = monOn_q;
	assign porDelayActive = state_q == ST_DELAY;
	// pin driven low only for power-on and supply resets
	assign rstPinOut = 1'h0;
	assign rstPinOe = state_q != ST_RUN &&
		(cause_q.por || cause_q == rsc_pkg::CAUSE_NONE);
endmodule

// File: tb/rsc_reset_ctrl_chk.sv
// assertion checker of the reset source controller
`timescale 1ns/1ps
module rsc_reset_ctrl_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrWrData,
	input wire logic [7:0] sfrRdData,
	input wire logic rstPinIn,
	input wire logic rstPinOe,
	input wire logic wdtTick,
	input wire rsc_pkg::rsc_flash_t flashAcc,
	input wire logic supplyMonitorOn,
	input wire logic sysRst,
	input wire logic porDelayActive
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// only a power-on reset may run the long delay
	logic porSeen_q;
	always_ff @(posedge sys_clk) begin
		if (rst)
			porSeen_q <= 1'b1;
		else if ($fell(porDelayActive))
			porSeen_q <= 1'b0;
	end
	a_low_bits: assert property (
		sfrRdEn && sfrAddr == 8'hff |=> sfrRdData[4:0] == 5'h00)
		else $error("low bits set");
	a_pin_drive: assert property (
		$rose(sysRst) && $past(sfrWrEn && sfrAddr == 8'hef &&
		sfrWrData[4], 2) |-> !rstPinOe) else $error("pin driven");
	a_sw_force: assert property (
		sfrWrEn && sfrAddr == 8'hef && sfrWrData[4] && !sysRst
		|-> ##[1:3] sysRst) else $error("no software reset");
	a_hold_len: assert property (
		$rose(sysRst) |=> sysRst [*4]) else $error("reset too short");
	a_delay_power: assert property (
		porDelayActive |-> porSeen_q) else $error("stray delay");
	a_tick_gap: assert property (
		wdtTick |=> !wdtTick [*8]) else $error("tick too fast");
	a_pin_reset: assert property (
		$fell(rstPinIn) && !sysRst |-> ##[1:5] sysRst)
		else $error("no pin reset");
	a_flash_fault: assert property (
		(flashAcc[4:1] != 4'h0 || flashAcc.wrAttempt && !supplyMonitorOn)
		&& !sysRst |-> ##[1:3] sysRst) else $error("no flash reset");
	c_power: cover property ($fell(porDelayActive));
	c_drive: cover property ($rose(sysRst) ##[0:3] rstPinOe);
	c_sw: cover property (sfrWrEn && sfrAddr == 8'hef && sfrWrData[4]);
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_chk chk_u (.sys_clk, .rst, .sfrAddr,
	.sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData, .rstPinIn, .rstPinOe,
	.wdtTick, .flashAcc, .supplyMonitorOn, .sysRst, .porDelayActive);

// File: tb/rsc_far_side.sv
// far side model: reset pin with pull-up, supply and clock sources
`timescale 1ns/1ps
module rsc_far_side (
	input wire logic extLow,
	input wire logic rstPinOut,
	input wire logic rstPinOe,
	input wire logic supplyLow,
	input wire logic warnLow,
	input wire logic stopClk,
	output logic rstPinIn,
	output logic supplyAboveReset,
	output logic supplyAboveWarn,
	output logic monClk
);
	// wired pin, pulled up unless someone pulls it low
	assign rstPinIn = !(extLow || rstPinOe && !rstPinOut);
	assign supplyAboveReset = !supplyLow;
	assign supplyAboveWarn = !(supplyLow || warnLow);
	// unrelated to sys_clk so the detector sees real edges
	initial monClk = 1'b0;
	always #3.1 if (!stopClk) monClk = ~monClk;
endmodule

// File: tb/rsc_reset_ctrl_tb.sv
// self-checking bench of the reset source controller
`timescale 1ns/1ps
module rsc_reset_ctrl_tb;
	localparam int POR_D = 20;
	logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, sfrWrEn = 1'b0;
	logic sfrRdEn = 1'b0, compOutLow = 1'b0, compWakeEn = 1'b0;
	logic wdtExpire = 1'b0, wdtStop = 1'b0, rtcAlarm = 1'b0;
	logic rtcOscFail = 1'b0, lowPower = 1'b0, extLow = 1'b0;
	logic supplyLow = 1'b0, warnLow = 1'b0, stopClk = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
	logic rstPinIn, rstPinOut, rstPinOe, supAR, supAW, monClk;
	logic supplyMonitorOn, wdtRun, wdtTick, sysRst;
	rsc_pkg::rsc_flash_t flashAcc = '0;
	int errors = 0, check_count = 0, cyc = 0;
	logic [31:0] seed = 32'he28d;
	always #2 sys_clk = ~sys_clk;
	rsc_far_side far_u (.extLow, .rstPinOut, .rstPinOe, .supplyLow,
		.warnLow, .stopClk, .rstPinIn, .supplyAboveReset(supAR),
		.supplyAboveWarn(supAW), .monClk);
	rsc_reset_ctrl #(.MCD_LIMIT(50), .POR_DELAY(POR_D)) dut_u (.sys_clk,
		.ce, .rst, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
		.rstPinIn, .rstPinOut, .rstPinOe, .supplyAboveReset(supAR),
		.supplyAboveWarn(supAW), .supplyMonitorOn, .compOutLow,
		.compWakeEn, .monClk, .wdtExpire, .wdtStop, .wdtRun, .wdtTick,
		.flashAcc, .rtcAlarm, .rtcOscFail, .lowPower, .sysRst,
		.porDelayActive());
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] flag(int b);
		return 8'h01 << b;
	endfunction
	function automatic logic [7:0] mon(logic r, logic w);
		return {1'b1, r, w, 5'h00};
	endfunction
	task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp1(string n, logic e, logic g);
		cmp8(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		tick(1);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		tick(1);
		sfrWrEn = 1'b0;
	endtask
	task automatic chkRd(logic [7:0] a, logic [7:0] e);
		tick(1);
		sfrAddr = a;
		sfrRdEn = 1'b1;
		tick(1);
		sfrRdEn = 1'b0;
		cmp8("sfrRdData", e, sfrRdData);
	endtask
	task automatic pulse(ref logic s);
		tick(1);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic hit(rsc_pkg::rsc_flash_t v);
		tick(1);
		flashAcc = v;
		tick(1);
		flashAcc = '0;
	endtask
	task automatic noReset(int n);
		logic s;
		s = 1'b0;
		repeat (n) begin
			tick(1);
			s |= sysRst;
		end
		cmp1("masked sysRst", 1'b0, s);
	endtask
	// counts watchdog ticks seen over n cycles of run
	task automatic cntTick(int n, logic [7:0] e);
		logic [7:0] c;
		c = 8'h00;
		repeat (n) begin
			tick(1);
			c += {7'h00, wdtTick};
		end
		cmp8("wdtTick count", e, c);
	endtask
	// waits for reset, drops every request, then checks release and cause
	task automatic rstSeq(string n, logic [7:0] e, logic oe, int lo = 4,
		int hi = 15);
		int k;
		k = 0;
		while (sysRst !== 1'b1 && k < 300) begin
			tick(1);
			k++;
		end
		cmp1("sysRst", 1'b1, sysRst);
		cmp1("rstPinOe", oe, rstPinOe);
		cmp1("rstPinOut", 1'b0, rstPinOut);
		{extLow, supplyLow, stopClk, lowPower, compOutLow} = '0;
		{rtcAlarm, rtcOscFail} = '0;
		k = 0;
		while (sysRst !== 1'b0 && k < 300) begin
			tick(1);
			k++;
		end
		cmp1("release time", 1'b1, k >= lo && k <= hi);
		chkRd(8'hef, e);
		$display("done %s", n);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		tick(10);
		rst = 1'b0;
		rstSeq("power", 8'h02, 1'b1, POR_D, 40);
		chkRd(8'hff, mon(1'b1, 1'b1));
		warnLow = 1'b1;
		tick(4);
		chkRd(8'hff, mon(1'b1, 1'b0));
		warnLow = 1'b0;
		wr(8'hff, 8'h80 | {6'h00, seed[1:0]});
		chkRd(8'hff, mon(1'b1, 1'b1));
		lowPower = 1'b1;
		pulse(wdtExpire);
		noReset(10);
		lowPower = 1'b0;
		pulse(wdtExpire);
		rstSeq("watchdog", flag(3), 1'b0);
		cmp1("wdtRun", 1'b1, wdtRun);
		cntTick(24, 8'h02);
		pulse(wdtStop);
		tick(1);
		cmp1("wdtRun", 1'b0, wdtRun);
		wr(8'hef, 8'h12);
		rstSeq("software", flag(rsc_pkg::SW_BIT), 1'b0);
		cmp1("wdtRun", 1'b1, wdtRun);
		lowPower = 1'b1;
		extLow = 1'b1;
		rstSeq("pin", flag(0), 1'b0);
		wr(8'hef, 8'h06);
		lowPower = 1'b1;
		stopClk = 1'b1;
		noReset(120);
		lowPower = 1'b0;
		rstSeq("clock", flag(rsc_pkg::MCD_BIT), 1'b0);
		wr(8'hef, 8'h22);
		lowPower = 1'b1;
		compOutLow = 1'b1;
		noReset(20);
		compWakeEn = 1'b1;
		rstSeq("comparator", flag(rsc_pkg::COMP_BIT), 1'b0);
		compWakeEn = 1'b0;
		for (int k = 0; k < 2; k++) begin
			wr(8'hef, 8'h82);
			lowPower = 1'b1;
			{rtcAlarm, rtcOscFail} = 2'(k + 1);
			rstSeq("rtc", flag(rsc_pkg::RTC_BIT), 1'b0);
		end
		for (int k = 1; k < 5; k++) begin
			seed = xs(seed);
			tick(seed[2:0]);
			hit(rsc_pkg::rsc_flash_t'(5'h01 << k));
			rstSeq("flash", flag(6), 1'b0);
		end
		wr(8'hef, 8'h00);
		supplyLow = 1'b1;
		noReset(20);
		supplyLow = 1'b0;
		hit(5'h01);
		noReset(10);
		wr(8'hff, 8'h00);
		hit(5'h01);
		rstSeq("flash write", flag(6), 1'b0);
		cmp1("supplyMonitorOn", 1'b0, supplyMonitorOn);
		wr(8'hff, 8'h80);
		wr(8'hef, 8'h02);
		supplyLow = 1'b1;
		rstSeq("supply", 8'h02, 1'b1);
		stop_test();
	end
endmodule
